// file: scf_pkg.sv
/*
 * shared constants of the serial command front end: timing, buffer sizes,
 * character codes, register offsets, field positions and reset values.
 * assumes a single 20 MHz core clock.
 */
package scf_pkg;
    // ==========================================================
    // timing
    localparam int SCF_CLK_HZ = 20000000;
    localparam int SCF_BAUD_POR = 9600;
    localparam logic [15:0] SCF_DIV_POR = 16'(SCF_CLK_HZ / SCF_BAUD_POR);
    localparam logic [3:0] SCF_FRAME_BITS = 4'ha;
    // ==========================================================
    // buffers
    localparam int SCF_IN_DEPTH = 32;
    localparam int SCF_OUT_DEPTH = 64;
    localparam int SCF_IN_AW = 5;
    localparam int SCF_OUT_AW = 6;
    // ==========================================================
    // characters
    localparam logic [7:0] SCF_CH_CR = 8'h0d;
    localparam logic [7:0] SCF_CH_LF = 8'h0a;
    localparam logic [7:0] SCF_CH_SP = 8'h20;
    localparam logic [7:0] SCF_CH_TAB = 8'h09;
    localparam logic [7:0] SCF_CH_SEMI = 8'h3b;
    // ==========================================================
    // register map
    localparam logic [7:0] SCF_REG_CTRL = 8'h00;
    localparam logic [7:0] SCF_REG_BAUD = 8'h04;
    localparam logic [7:0] SCF_REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] SCF_REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] SCF_REG_COMM_ERR = 8'h10;
    localparam logic [7:0] SCF_REG_EVENT = 8'h14;
    localparam logic [7:0] SCF_REG_STATE = 8'h18;
    // ctrl fields
    localparam int SCF_CTRL_ECHO_BIT = 0;
    localparam int SCF_CTRL_FLOW_BIT = 1;
    localparam logic SCF_ECHO_POR = 1'b0;
    localparam logic SCF_FLOW_POR = 1'b1;
    // interrupt status fields
    localparam int SCF_IRQ_OVF_BIT = 0;
    localparam int SCF_IRQ_CLR_BIT = 1;
    localparam int SCF_IRQ_LINE_BIT = 2;
    // error fields
    localparam int SCF_CE_OVF_BIT = 4;
    localparam int SCF_EV_ERR_BIT = 4;
endpackage : scf_pkg

// file: scf_if.sv
/*
 * link between the front end core and its serial engine.
 * assumes both ends run on the core clock.
 */
`timescale 1ns/1ns
interface scf_if;
    logic [15:0] div;
    logic rx_valid;
    logic [7:0] rx_data;
    logic brk;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    modport core (output div, output tx_valid, output tx_data,
                  input rx_valid, input rx_data, input brk, input tx_ready);
    modport uart (input div, input tx_valid, input tx_data,
                  output rx_valid, output rx_data, output brk, output tx_ready);
endinterface : scf_if

// file: scf_mem.sv
/*
 * simple dual port byte memory with registered read data.
 * assumes one writer and one reader on the core clock.
 */
`timescale 1ns/1ns
module scf_mem #(
    parameter int AW = 5
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : scf_mem

// file: scf_uart.sv
/*
 * 8n1 serial engine: receiver, transmitter and break detector.
 * assumes the divider gives core cycles per bit and is at least 4.
 */
`timescale 1ns/1ns
module scf_uart (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic rxd_i,
    output logic txd_o,
    scf_if.uart lk
);
    import scf_pkg::*;

    logic rx_m_r, rx_s_r;
    logic rx_busy_r, rx_busy_nxt;
    logic [15:0] rx_cnt_r, rx_cnt_nxt;
    logic [3:0] rx_bit_r, rx_bit_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic rx_vld_r, rx_vld_nxt;
    logic [19:0] low_r, low_nxt;
    logic brk_r, brk_nxt;
    logic tx_busy_r, tx_busy_nxt;
    logic [15:0] tx_cnt_r, tx_cnt_nxt;
    logic [3:0] tx_bit_r, tx_bit_nxt;
    logic [9:0] tx_sh_r, tx_sh_nxt;
    logic [19:0] frame;

    // ==========================================================
    // receive and break
    assign frame = 20'(lk.div * SCF_FRAME_BITS);

    always_comb begin
        rx_busy_nxt = rx_busy_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        rx_vld_nxt = 1'b0;
        if (!rx_busy_r) begin
            if (!rx_s_r) begin
                rx_busy_nxt = 1'b1;
                rx_cnt_nxt = {1'b0, lk.div[15:1]};
                rx_bit_nxt = 4'h0;
            end
        end else if (rx_cnt_r != 16'h0000) begin
            rx_cnt_nxt = rx_cnt_r - 16'h0001;
        end else begin
            rx_cnt_nxt = lk.div - 16'h0001;
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
                rx_busy_nxt = !rx_s_r;
            end else if (rx_bit_r == 4'h9) begin
                // a low stop bit is a framing error, so a break adds no byte
                rx_busy_nxt = 1'b0;
                rx_vld_nxt = rx_s_r; // RULE14
            end else begin
                rx_sh_nxt = {rx_s_r, rx_sh_r[7:1]};
            end
        end
        // longer than one whole frame of space means break
        low_nxt = rx_s_r ? 20'h00000 : ((low_r <= frame) ? low_r + 20'h00001 : low_r); // RULE18
        brk_nxt = !rx_s_r && (low_r == frame); // RULE18
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_vld_r <= 1'b0;
            low_r <= 20'h00000;
            brk_r <= 1'b0;
        end else begin
            rx_m_r <= rxd_i;
            rx_s_r <= rx_m_r;
            rx_busy_r <= rx_busy_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_vld_r <= rx_vld_nxt;
            low_r <= low_nxt;
            brk_r <= brk_nxt;
        end
    end

    assign lk.rx_valid = rx_vld_r;
    assign lk.rx_data = rx_sh_r;
    assign lk.brk = brk_r;

    // ==========================================================
    // transmit
    always_comb begin
        tx_busy_nxt = tx_busy_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_bit_nxt = tx_bit_r;
        tx_sh_nxt = tx_sh_r;
        if (!tx_busy_r) begin
            if (lk.tx_valid) begin
                tx_busy_nxt = 1'b1;
                tx_sh_nxt = {1'b1, lk.tx_data, 1'b0}; // RULE14
                tx_cnt_nxt = lk.div - 16'h0001;
                tx_bit_nxt = 4'h0;
            end
        end else if (tx_cnt_r != 16'h0000) begin
            tx_cnt_nxt = tx_cnt_r - 16'h0001;
        end else begin
            tx_cnt_nxt = lk.div - 16'h0001;
            tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
            tx_bit_nxt = tx_bit_r + 4'h1;
            tx_busy_nxt = (tx_bit_r != 4'h9);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_busy_r <= 1'b0;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 10'h3ff;
        end else begin
            tx_busy_r <= tx_busy_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt;
        end
    end

    assign txd_o = tx_sh_r[0];
    assign lk.tx_ready = !tx_busy_r;
endmodule : scf_uart

// file: scf_top.sv
/*
 * serial command front end: line input buffer, command splitter, response
 * queue, device clear, stream tracking and register port.
 * assumes an executor on the core clock consumes command bytes and
 * supplies response bytes; measurement state lives outside this block.
 */
// Operation
// RULE1 - power-on link runs 9600 baud, no parity, rts/cts flow control on
// RULE2 - power-on echo is off, received characters are not returned
// RULE3 - stored settings restore at power-on; interface settings are exceptions
// RULE4 - received characters go into a 32-byte input buffer
// RULE5 - line is only parsed once cr or lf terminator arrives
// RULE6 - query responses queue in a 64-byte output queue before sending
// RULE7 - input overflow discards both input buffer and output queue; a byte arriving while a line drains clears only the output queue
// RULE8 - overflow flags comm error status and standard event status
// RULE9 - break on receive line returns interface to power-on configuration
// RULE10 - after device clear link is 9600 baud with echo off
// RULE11 - device clear touches only the communication interface
// RULE12 - device clear ends any streaming readout in progress
// RULE13 - host sends break, mainframe sends its module reset command
// RULE14 - character format is 8 data bits, no parity, 1 stop
// RULE15 - semicolon separated commands in one line execute in turn
// RULE16 - null commands and whitespace are ignored without error
// RULE17 - stream count zero runs until stop; omitted count means one
// RULE18 - break is space held longer than one full character frame
`timescale 1ns/1ns
module scf_top (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    // serial link
    input wire logic RXD_I,
    output logic TXD_O,
    input wire logic HOST_CTS_I,
    output logic DEV_RTS_O,
    input wire logic MODULE_RESET_I,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    output logic IRQ_O,
    // command bytes to executor
    output logic CMD_VALID_O,
    output logic CMD_END_O,
    output logic [7:0] CMD_DATA_O,
    input wire logic CMD_READY_I,
    // response bytes from executor
    input wire logic RESP_VALID_I,
    input wire logic [7:0] RESP_DATA_I,
    output logic RESP_READY_O,
    // streaming readout
    input wire logic STREAM_START_I,
    input wire logic [15:0] STREAM_COUNT_I,
    input wire logic STREAM_CONV_I,
    input wire logic STOP_STREAM_I,
    output logic STREAMING_O
);
    import scf_pkg::*;

    typedef enum {ST_COLLECT, ST_FETCH, ST_SHOW, ST_END} scf_state_t;

    scf_if lk ();

    scf_state_t st_r, st_nxt;
    logic [5:0] in_cnt_r, in_cnt_nxt;
    logic [5:0] idx_r, idx_nxt;
    logic has_r, has_nxt;
    logic skip_r, skip_nxt;
    logic [6:0] out_wp_r, out_wp_nxt, out_rp_r, out_rp_nxt;
    logic pend_r, pend_nxt;
    logic echo_r, echo_nxt, flow_r, flow_nxt;
    logic [15:0] div_r, div_nxt;
    logic [2:0] irq_st_r, irq_st_nxt, irq_mk_r, irq_mk_nxt;
    logic [7:0] ce_r, ce_nxt, ev_r, ev_nxt;
    logic strm_r, strm_nxt;
    logic [15:0] left_r, left_nxt;
    logic [15:0] rdata_nxt;
    logic mr_m_r, mr_s_r, cts_m_r, cts_s_r;
    logic clr, ovf, line_ev, is_term, in_full, out_full, out_empty;
    logic echo_push, resp_push, out_we, out_rd;
    logic [7:0] out_wdata, in_q, out_q;

    // ==========================================================
    // helpers
    function automatic logic [15:0] w1c(input logic [15:0] cur, input logic hit,
                                        input logic [15:0] wd, input logic [15:0] set);
        // a set in the clearing cycle survives
        return (cur & ~(hit ? wd : 16'h0000)) | set;
    endfunction : w1c

    function automatic logic is_space(input logic [7:0] c);
        return (c == SCF_CH_SP) || (c == SCF_CH_TAB);
    endfunction : is_space

    // ==========================================================
    // memories and serial engine
    scf_mem #(.AW(SCF_IN_AW)) u_in_mem (
        .clk_i(CORE_CLK_I),
        .we_i(lk.rx_valid && st_r == ST_COLLECT && !is_term && !in_full && !skip_r),
        .waddr_i(in_cnt_r[4:0]),
        .wdata_i(lk.rx_data),
        .raddr_i(idx_r[4:0]),
        .rdata_o(in_q)
    );

    scf_mem #(.AW(SCF_OUT_AW)) u_out_mem (
        .clk_i(CORE_CLK_I),
        .we_i(out_we),
        .waddr_i(out_wp_r[5:0]),
        .wdata_i(out_wdata),
        .raddr_i(out_rp_r[5:0]),
        .rdata_o(out_q)
    );

    scf_uart u_uart (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .rxd_i(RXD_I),
        .txd_o(TXD_O),
        .lk(lk.uart)
    );

    // ==========================================================
    // events
    assign clr = lk.brk || mr_s_r; // RULE9 RULE13
    assign is_term = (lk.rx_data == SCF_CH_CR) || (lk.rx_data == SCF_CH_LF);
    assign in_full = (in_cnt_r == 6'(SCF_IN_DEPTH)); // RULE4
    // bytes arriving while a line drains have no room either
    assign ovf = lk.rx_valid && !is_term && (st_r != ST_COLLECT || in_full) && !skip_r;
    assign line_ev = lk.rx_valid && is_term && st_r == ST_COLLECT;
    assign out_full = (out_wp_r - out_rp_r) == 7'(SCF_OUT_DEPTH); // RULE6
    assign out_empty = (out_wp_r == out_rp_r);
    assign echo_push = echo_r && lk.rx_valid && !out_full; // RULE2
    assign RESP_READY_O = !out_full && !echo_push && !clr && !ovf;
    assign resp_push = RESP_VALID_I && RESP_READY_O;
    assign out_we = echo_push || resp_push;
    assign out_wdata = echo_push ? lk.rx_data : RESP_DATA_I;
    assign out_rd = !out_empty && !pend_r && lk.tx_ready && (cts_s_r || !flow_r) && !clr;

    // ==========================================================
    // line collection and command splitting
    always_comb begin
        st_nxt = st_r;
        in_cnt_nxt = in_cnt_r;
        idx_nxt = idx_r;
        has_nxt = has_r;
        skip_nxt = skip_r;
        case (st_r)
            ST_COLLECT: begin
                if (lk.rx_valid) begin
                    if (is_term) begin
                        skip_nxt = 1'b0;
                        idx_nxt = 6'h00;
                        has_nxt = 1'b0;
                        if (in_cnt_r != 6'h00 && !skip_r) begin
                            st_nxt = ST_FETCH; // RULE5
                        end
                    end else if (in_full) begin
                        in_cnt_nxt = 6'h00; // RULE7
                        skip_nxt = 1'b1; // RULE7
                    end else if (!skip_r) begin
                        in_cnt_nxt = in_cnt_r + 6'h01; // RULE4
                    end
                end
            end
            ST_FETCH: begin
                st_nxt = ST_SHOW;
            end
            ST_SHOW: begin
                if (is_space(in_q) || in_q == SCF_CH_SEMI || CMD_READY_I) begin
                    idx_nxt = idx_r + 6'h01;
                    if (in_q == SCF_CH_SEMI) begin
                        st_nxt = has_r ? ST_END : ST_FETCH; // RULE15 RULE16
                    end else begin
                        has_nxt = has_r || !is_space(in_q); // RULE16
                        st_nxt = ST_FETCH;
                    end
                    if (idx_r + 6'h01 == in_cnt_r && st_nxt == ST_FETCH) begin
                        st_nxt = has_nxt ? ST_END : ST_COLLECT;
                    end
                end
            end
            ST_END: begin
                if (CMD_READY_I) begin
                    has_nxt = 1'b0;
                    st_nxt = (idx_r == in_cnt_r) ? ST_COLLECT : ST_FETCH; // RULE15
                end
            end
            default: st_nxt = ST_COLLECT;
        endcase
        if (st_r != ST_COLLECT && st_nxt == ST_COLLECT) begin
            in_cnt_nxt = 6'h00;
        end
        if (clr) begin
            st_nxt = ST_COLLECT; // RULE9
            in_cnt_nxt = 6'h00;
            skip_nxt = 1'b0;
            has_nxt = 1'b0;
        end
    end

    // the executor sees the byte only while it is not blank or a separator, and always during the end token
    assign CMD_VALID_O = (st_r == ST_SHOW && !is_space(in_q) && in_q != SCF_CH_SEMI) || st_r == ST_END;
    assign CMD_END_O = (st_r == ST_END);
    assign CMD_DATA_O = in_q;
    assign DEV_RTS_O = !flow_r || (st_r == ST_COLLECT && !in_full); // RULE1

    // ==========================================================
    // response queue
    always_comb begin
        out_wp_nxt = out_we ? out_wp_r + 7'h01 : out_wp_r;
        out_rp_nxt = out_rd ? out_rp_r + 7'h01 : out_rp_r;
        pend_nxt = out_rd;
        if (ovf || clr) begin
            out_wp_nxt = 7'h00; // RULE7
            out_rp_nxt = 7'h00;
            pend_nxt = 1'b0;
        end
    end

    assign lk.tx_valid = pend_r;
    assign lk.tx_data = out_q;
    assign lk.div = div_r;

    // ==========================================================
    // registers, status and streaming
    always_comb begin
        echo_nxt = echo_r;
        flow_nxt = flow_r;
        div_nxt = div_r;
        irq_mk_nxt = irq_mk_r;
        if (WR_I && ADDR_I == SCF_REG_CTRL) begin
            echo_nxt = WDATA_I[SCF_CTRL_ECHO_BIT];
            flow_nxt = WDATA_I[SCF_CTRL_FLOW_BIT];
        end else if (WR_I && ADDR_I == SCF_REG_BAUD) begin
            div_nxt = WDATA_I;
        end else if (WR_I && ADDR_I == SCF_REG_IRQ_MASK) begin
            irq_mk_nxt = WDATA_I[2:0];
        end
        if (clr) begin
            div_nxt = SCF_DIV_POR; // RULE10
            echo_nxt = SCF_ECHO_POR; // RULE10
            flow_nxt = SCF_FLOW_POR; // RULE9
        end
        irq_st_nxt = 3'(w1c(16'(irq_st_r), WR_I && ADDR_I == SCF_REG_IRQ_STAT, WDATA_I,
                            16'({line_ev, clr, ovf})));
        ce_nxt = 8'(w1c(16'(ce_r), WR_I && ADDR_I == SCF_REG_COMM_ERR, WDATA_I,
                        16'(ovf) << SCF_CE_OVF_BIT)); // RULE8
        ev_nxt = 8'(w1c(16'(ev_r), WR_I && ADDR_I == SCF_REG_EVENT, WDATA_I,
                        16'(ovf) << SCF_EV_ERR_BIT)); // RULE8
        strm_nxt = strm_r;
        left_nxt = left_r;
        if (STREAM_START_I) begin
            strm_nxt = 1'b1;
            left_nxt = STREAM_COUNT_I; // RULE17
        end else if (STREAM_CONV_I && strm_r && left_r != 16'h0000) begin
            left_nxt = left_r - 16'h0001;
            strm_nxt = (left_r != 16'h0001); // RULE17
        end
        if (STOP_STREAM_I || clr) begin
            strm_nxt = 1'b0; // RULE12 RULE17
        end
        rdata_nxt = 16'h0000;
        if (ADDR_I == SCF_REG_CTRL) begin
            rdata_nxt = 16'({flow_r, echo_r});
        end else if (ADDR_I == SCF_REG_BAUD) begin
            rdata_nxt = div_r;
        end else if (ADDR_I == SCF_REG_IRQ_STAT) begin
            rdata_nxt = 16'(irq_st_r);
        end else if (ADDR_I == SCF_REG_IRQ_MASK) begin
            rdata_nxt = 16'(irq_mk_r);
        end else if (ADDR_I == SCF_REG_COMM_ERR) begin
            rdata_nxt = 16'(ce_r);
        end else if (ADDR_I == SCF_REG_EVENT) begin
            rdata_nxt = 16'(ev_r);
        end else if (ADDR_I == SCF_REG_STATE) begin
            rdata_nxt = {out_wp_r - out_rp_r, strm_r, skip_r, 1'b0, in_cnt_r};
        end
        if (!RD_I) begin
            rdata_nxt = 16'h0000;
        end
    end

    assign IRQ_O = |(irq_st_r & irq_mk_r);
    assign STREAMING_O = strm_r;

    // device clear leaves measurement state alone: nothing here reaches it
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin // RULE11
        if (!RST_B_I) begin
            st_r <= ST_COLLECT;
            in_cnt_r <= 6'h00;
            idx_r <= 6'h00;
            has_r <= 1'b0;
            skip_r <= 1'b0;
            out_wp_r <= 7'h00;
            out_rp_r <= 7'h00;
            pend_r <= 1'b0;
            // interface comes up from constants, not from stored settings
            echo_r <= SCF_ECHO_POR; // RULE2 RULE3
            flow_r <= SCF_FLOW_POR; // RULE1
            div_r <= SCF_DIV_POR; // RULE1
            irq_st_r <= 3'h0;
            irq_mk_r <= 3'h0;
            ce_r <= 8'h00;
            ev_r <= 8'h00;
            strm_r <= 1'b0;
            left_r <= 16'h0000;
            RDATA_O <= 16'h0000;
            mr_m_r <= 1'b0;
            mr_s_r <= 1'b0;
            cts_m_r <= 1'b0;
            cts_s_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            in_cnt_r <= in_cnt_nxt;
            idx_r <= idx_nxt;
            has_r <= has_nxt;
            skip_r <= skip_nxt;
            out_wp_r <= out_wp_nxt;
            out_rp_r <= out_rp_nxt;
            pend_r <= pend_nxt;
            echo_r <= echo_nxt;
            flow_r <= flow_nxt;
            div_r <= div_nxt;
            irq_st_r <= irq_st_nxt;
            irq_mk_r <= irq_mk_nxt;
            ce_r <= ce_nxt;
            ev_r <= ev_nxt;
            strm_r <= strm_nxt;
            left_r <= left_nxt;
            RDATA_O <= rdata_nxt;
            mr_m_r <= MODULE_RESET_I;
            mr_s_r <= mr_m_r;
            cts_m_r <= HOST_CTS_I;
            cts_s_r <= cts_m_r;
        end
    end
endmodule : scf_top

// file: scf_host_model.sv
/* host end of the serial link: sends 8n1 frames and breaks.
   assumes the bench gives the bit time in core cycles. */
`timescale 1ns/1ns
module scf_host_model (
    // clock
    input wire logic clk_i,
    // serial line toward the device
    output logic rxd_o
);
    // line idles at mark between frames
    initial rxd_o = 1'b1;
    // =========
    // frames
    task automatic send_byte(input int div, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= f[i];
            repeat (div) @(posedge clk_i);
        end
    endtask : send_byte
    task automatic send_break(input int cycles);
        rxd_o <= 1'b0;
        repeat (cycles) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask : send_break
endmodule : scf_host_model

// file: scf_top_checker.sv
/* port checker of the front end top.
   assumes one clock domain; bound to scf_top below. */
`timescale 1ns/1ns
module scf_top_checker (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    // watched ports
    input wire logic TXD_O,
    input wire logic DEV_RTS_O,
    input wire logic MODULE_RESET_I,
    input wire logic CMD_VALID_O,
    input wire logic CMD_END_O,
    input wire logic CMD_READY_I,
    input wire logic STREAM_START_I,
    input wire logic STOP_STREAM_I,
    input wire logic STREAMING_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    // =========
    // properties
    property p_end; CMD_END_O |-> CMD_VALID_O ##1 !($past(CMD_READY_I) && CMD_END_O); endproperty
    a_end: assert property (p_end) else $error("bad end token");
    property p_rts; $rose(RST_B_I) |-> DEV_RTS_O; endproperty
    a_rts: assert property (p_rts) else $error("flow control not ready");
    property p_echo; $rose(RST_B_I) |-> TXD_O [*8]; endproperty
    a_echo: assert property (p_echo) else $error("transmit after reset");
    property p_clr_cmd; MODULE_RESET_I [*4] |-> ##[0:3] !CMD_VALID_O; endproperty
    a_clr_cmd: assert property (p_clr_cmd) else $error("command in clear");
    property p_clr_strm; MODULE_RESET_I [*4] |-> ##[0:3] !STREAMING_O; endproperty
    a_clr_strm: assert property (p_clr_strm) else $error("stream kept in clear");
    property p_go; STREAM_START_I && !STOP_STREAM_I && !MODULE_RESET_I |-> ##[1:2] STREAMING_O; endproperty
    a_go: assert property (p_go) else $error("stream did not start");
    property p_stop; STOP_STREAM_I |-> ##[1:2] !STREAMING_O; endproperty
    a_stop: assert property (p_stop) else $error("stream did not stop");
    property p_start_bit; $fell(TXD_O) |-> !TXD_O [*4]; endproperty
    a_start_bit: assert property (p_start_bit) else $error("short start bit");
endmodule : scf_top_checker
bind scf_top scf_top_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .TXD_O(TXD_O),
    .DEV_RTS_O(DEV_RTS_O), .MODULE_RESET_I(MODULE_RESET_I), .CMD_VALID_O(CMD_VALID_O),
    .CMD_END_O(CMD_END_O), .STREAM_START_I(STREAM_START_I), .STOP_STREAM_I(STOP_STREAM_I),
    .CMD_READY_I(CMD_READY_I), .STREAMING_O(STREAMING_O));

// file: serial_command_front_end_bench.sv
/* self-checking bench of the front end.
   assumes the design compiles first. */
`timescale 1ns/1ns
module serial_command_front_end_bench;
    import scf_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, cts = 1'b0, mrst = 1'b0;
    logic rv = 1'b0, ss = 1'b0, conv = 1'b0, stop = 1'b0, crdy = 1'b1;
    logic [7:0] addr = 8'h00, rdat = 8'h00, cd;
    logic [15:0] wdata = 16'h0000, scnt = 16'h0000, rdata;
    logic rxd, irq, cv, ce, rts, txd, rr, strm;
    logic [15:0] cmdq[$];
    logic [15:0] exp_cmd[4] = '{16'h0041, 16'h0100, 16'h0042, 16'h0100};
    int fails = 0, samples_checked = 0, div = SCF_DIV_POR;
    always #25 clk = ~clk;
    scf_top u_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .RXD_I(rxd), .TXD_O(txd), .HOST_CTS_I(cts),
        .DEV_RTS_O(rts), .MODULE_RESET_I(mrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .IRQ_O(irq), .CMD_VALID_O(cv), .CMD_END_O(ce), .CMD_DATA_O(cd),
        .CMD_READY_I(crdy), .RESP_VALID_I(rv), .RESP_DATA_I(rdat), .RESP_READY_O(rr),
        .STREAM_START_I(ss), .STREAM_COUNT_I(scnt), .STREAM_CONV_I(conv), .STOP_STREAM_I(stop),
        .STREAMING_O(strm));
    scf_host_model u_host (.clk_i(clk), .rxd_o(rxd));
    // offer taken only with ready
    always @(posedge clk) if (cv === 1'b1 && crdy) cmdq.push_back(ce ? 16'h0100 : {8'h00, cd});
    // =========
    // tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr16
    task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk) chk(rdata, exp);
    endtask : rd16
    task automatic send(input string s);
        foreach (s[i]) u_host.send_byte(div, s[i]);
    endtask : send
    task automatic strm_go(input logic [15:0] n);
        @(posedge clk);
        scnt <= n;
        ss <= 1'b1;
        @(posedge clk);
        ss <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : strm_go
    task automatic complete_run;
        if (fails == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #2000000;
        fails++;
        complete_run();
    end
    // =========
    // sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd16(SCF_REG_CTRL, 16'h0002);
        rd16(SCF_REG_BAUD, SCF_DIV_POR);
        rd16(8'h1c, 16'h0000);
        wr16(SCF_REG_BAUD, 16'h0008);
        div = 8;
        send("A; ;B");
        chk(16'(cmdq.size()), 16'h0000);
        send("\r");
        crdy <= 1'b0;
        repeat (20) @(posedge clk);
        crdy <= 1'b1;
        repeat (100) @(posedge clk);
        chk(16'(cmdq.size()), 16'h0004);
        foreach (exp_cmd[i]) chk(cmdq[i], exp_cmd[i]);
        wr16(SCF_REG_IRQ_STAT, 16'hffff);
        wr16(SCF_REG_IRQ_MASK, 16'h0001);
        @(posedge clk);
        rv <= 1'b1;
        rdat <= 8'h55;
        @(posedge clk);
        rv <= 1'b0;
        rd16(SCF_REG_STATE, 16'h0200);
        chk(16'(txd), 16'h0001);
        repeat (32) u_host.send_byte(div, 8'h78);
        rd16(SCF_REG_STATE, 16'h0220);
        u_host.send_byte(div, 8'h78);
        rd16(SCF_REG_STATE, 16'h0080);
        rd16(SCF_REG_COMM_ERR, 16'h0010);
        rd16(SCF_REG_EVENT, 16'h0010);
        chk(16'(irq), 16'h0001);
        send("\r");
        repeat (100) @(posedge clk);
        chk(16'(cmdq.size()), 16'h0004);
        wr16(SCF_REG_IRQ_STAT, 16'h0001);
        @(posedge clk) chk(16'(irq), 16'h0000);
        cts <= 1'b1;
        rv <= 1'b1;
        @(posedge clk);
        rv <= 1'b0;
        repeat (120) @(posedge clk);
        rd16(SCF_REG_STATE, 16'h0000);
        strm_go(16'h0001);
        chk(16'(strm), 16'h0001);
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        repeat (3) @(posedge clk);
        chk(16'(strm), 16'h0000);
        strm_go(16'h0000);
        conv <= 1'b1;
        repeat (3) @(posedge clk);
        conv <= 1'b0;
        stop <= 1'b1;
        #1 chk(16'(strm), 16'h0001);
        @(posedge clk);
        stop <= 1'b0;
        repeat (3) @(posedge clk);
        chk(16'(strm), 16'h0000);
        wr16(SCF_REG_CTRL, 16'h0001);
        strm_go(16'h0000);
        u_host.send_break(12 * div);
        repeat (10) @(posedge clk);
        chk(16'(strm), 16'h0000);
        rd16(SCF_REG_BAUD, SCF_DIV_POR);
        rd16(SCF_REG_CTRL, 16'h0002);
        strm_go(16'h0000);
        mrst <= 1'b1;
        repeat (6) @(posedge clk);
        mrst <= 1'b0;
        chk(16'(strm), 16'h0000);
        complete_run();
    end
endmodule : serial_command_front_end_bench
